// ===== src/mdl_pkg.sv
// package: register map, field positions, source codes and shared types of the modulator
// assumes: one core_clk domain, apb register access with byte addresses
package mdl_pkg;

  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam logic [7:0] OFF_CTRL0 = 8'h00;
  localparam logic [7:0] OFF_CTRL1 = 8'h04;
  localparam logic [7:0] OFF_SRC   = 8'h08;
  localparam logic [7:0] OFF_CARRIER_HIGH_SIGNAL  = 8'h0C;
  localparam logic [7:0] OFF_CARRIER_LOW_SIGNAL  = 8'h10;
  localparam logic [7:0] OFF_ROUTE = 8'h14;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int EN_BIT     = 7;
  localparam int OUT_BIT    = 5;
  localparam int OUTPUT_INVERT_BIT   = 4;
  localparam int SWBIT_BIT  = 0;
  localparam int HIGH_CARRIER_INVERT_BIT  = 5;
  localparam int HIGH_CARRIER_SYNC_ENABLE_BIT = 4;
  localparam int LOW_CARRIER_INVERT_BIT  = 1;
  localparam int LOW_CARRIER_SYNC_ENABLE_BIT = 0;
  localparam int ROUTE_BIT  = 0;
  localparam int SEL_W      = 5;
  localparam int PERIPH_N   = 8;

  // ****************************************************************
  // source codes and reset values
  // ****************************************************************
  localparam logic [4:0] SRC_VSS    = 5'h00;
  localparam logic [4:0] SRC_SWBIT  = 5'h01;
  localparam logic [4:0] SRC_PIN    = 5'h02;
  localparam logic [4:0] SRC_PERIPH = 5'h08;
  localparam logic [4:0] SEL_RST    = 5'h00;
  localparam logic       BIT_RST    = 1'b0;
  localparam logic [31:0] DATA_RST  = 32'h0000_0000;

  typedef struct packed {
    logic       en;
    logic       output_invert;
    logic       swbit;
    logic       high_carrier_invert;
    logic       high_carrier_sync_enable;
    logic       low_carrier_invert;
    logic       low_carrier_sync_enable;
    logic [4:0] ms;
    logic [4:0] ch;
    logic [4:0] cl;
    logic       route;
  } mdl_cfg_t;

  typedef struct packed {
    logic modulator_signal;
    logic carrier_high_signal;
    logic carrier_low_signal;
  } mdl_sig_t;

  typedef enum logic [1:0] {
    MDL_USE_LOW  = 2'b00,
    MDL_USE_HIGH = 2'b01
  } mdl_sel_t;

endpackage

// ===== src/mdl_src_mux.sv
// source selector for one modulator or carrier input
// assumes: peripheral inputs are on core_clk, pin input already synchronised
`timescale 1ns/10ps
module mdl_src_mux
(
  input  wire logic [4:0] code,
  input  wire logic       swbit,
  input  wire logic       pin,
  input  wire logic [7:0] periph,
  output      logic       sel
);

  // unknown codes read as ground so a bad setting stays quiet
  always_comb
  begin
    sel = 1'b0;
    if (code == mdl_pkg::SRC_SWBIT)
    begin
      sel = swbit;
    end
    else if (code == mdl_pkg::SRC_PIN)
    begin
      sel = pin;
    end
    else if (code[4:3] == mdl_pkg::SRC_PERIPH[4:3])
    begin
      sel = periph[code[2:0]];
    end
  end

endmodule // mdl_src_mux

// ===== src/mdl_sync2.sv
// two flip-flop synchroniser for the pin inputs
// assumes: inputs are asynchronous to core_clk
`timescale 1ns/10ps
module mdl_sync2
(
  input  wire logic            core_clk,
  input  wire logic            rst,
  input  wire mdl_pkg::mdl_sig_t din,
  output      mdl_pkg::mdl_sig_t dout
);

  mdl_pkg::mdl_sig_t meta;
  mdl_pkg::mdl_sig_t next_meta;
  mdl_pkg::mdl_sig_t next_dout;

  always_comb
  begin
    next_meta = din;
    next_dout = meta;
  end

  // first stage feeds only the second
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      meta <= '0;
      dout <= '0;
    end
    else
    begin
      meta <= next_meta;
      dout <= next_dout;
    end
  end

endmodule // mdl_sync2

// ===== src/mdl_top.sv
// modulator core: apb registers, source selection, carrier sync and output mixing
// assumes: apb master on core_clk, pins asynchronous, peripheral sources on core_clk
// Notes on behaviour
// - output is the modulator mixed with the selected carrier, sent toward the pin
// - modulator high selects the high carrier
// - modulator low selects the low carrier
// - mixing runs only while software holds the enable bit set
// - while disabled both carriers are forced to ground
// - while disabled the modulator comes from the software bit
// - disabling keeps the stored source selections untouched
// - re-enabling applies the stored source selections again
// - each source is a peripheral output, an input pin, the software bit or ground
// - a routing bit lets the output drive the pin
// - unrouted output still keeps mixing internally
// - sync bits delay a carrier switch until the old carrier falls
// - separate bits invert the high and low carrier inputs
// - output invert bit makes the output idle high
// - reset disables the block and restores register defaults
//
// Register access over APB and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
module mdl_top
(
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output      logic [31:0] prdata,
  output      logic        pready,
  output      logic        pslverr,
  input  wire logic        mod_pin,
  input  wire logic        carrier_high_signal_pin,
  input  wire logic        carrier_low_signal_pin,
  input  wire logic [7:0]  periph_in,
  output      logic        modulated_output_pin,
  output      logic        modulated_output_pin_oe
);

  // ****************************************************************
  // configuration registers
  // ****************************************************************
  mdl_pkg::mdl_cfg_t cfg;
  mdl_pkg::mdl_cfg_t next_cfg;
  logic              wr_en;

  localparam logic BIT_RST_C = mdl_pkg::BIT_RST;

  assign wr_en = psel & penable & pready & pwrite;

  always_comb
  begin
    next_cfg = cfg;
    if (wr_en)
    begin
      case (paddr)
        mdl_pkg::OFF_CTRL0:
        begin
          next_cfg.en    = pwdata[mdl_pkg::EN_BIT];
          next_cfg.output_invert  = pwdata[mdl_pkg::OUTPUT_INVERT_BIT];
          next_cfg.swbit = pwdata[mdl_pkg::SWBIT_BIT];
        end
        mdl_pkg::OFF_CTRL1:
        begin
          next_cfg.high_carrier_invert  = pwdata[mdl_pkg::HIGH_CARRIER_INVERT_BIT];
          next_cfg.high_carrier_sync_enable = pwdata[mdl_pkg::HIGH_CARRIER_SYNC_ENABLE_BIT];
          next_cfg.low_carrier_invert  = pwdata[mdl_pkg::LOW_CARRIER_INVERT_BIT];
          next_cfg.low_carrier_sync_enable = pwdata[mdl_pkg::LOW_CARRIER_SYNC_ENABLE_BIT];
        end
        mdl_pkg::OFF_SRC:
        begin
          next_cfg.ms = pwdata[mdl_pkg::SEL_W-1:0];
        end
        mdl_pkg::OFF_CARRIER_HIGH_SIGNAL:
        begin
          next_cfg.ch = pwdata[mdl_pkg::SEL_W-1:0];
        end
        mdl_pkg::OFF_CARRIER_LOW_SIGNAL:
        begin
          next_cfg.cl = pwdata[mdl_pkg::SEL_W-1:0];
        end
        mdl_pkg::OFF_ROUTE:
        begin
          next_cfg.route = pwdata[mdl_pkg::ROUTE_BIT];
        end
        default:
        begin
          next_cfg = cfg;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      cfg.en     <= BIT_RST_C;
      cfg.output_invert   <= BIT_RST_C;
      cfg.swbit  <= BIT_RST_C;
      cfg.high_carrier_invert  <= BIT_RST_C;
      cfg.high_carrier_sync_enable <= BIT_RST_C;
      cfg.low_carrier_invert  <= BIT_RST_C;
      cfg.low_carrier_sync_enable <= BIT_RST_C;
      cfg.ms     <= mdl_pkg::SEL_RST;
      cfg.ch     <= mdl_pkg::SEL_RST;
      cfg.cl     <= mdl_pkg::SEL_RST;
      cfg.route  <= BIT_RST_C;
    end
    else
    begin
      cfg <= next_cfg;
    end
  end

  // ****************************************************************
  // apb slave
  // ****************************************************************
  // no wait states: data is set up in the setup cycle, answer comes on the first access edge
  logic [31:0] next_prdata;
  logic        next_pready;
  logic        next_pslverr;
  logic        setup;

  assign setup = psel & ~penable;

  always_comb
  begin
    next_pready  = setup;
    next_pslverr = 1'b0;
    next_prdata  = mdl_pkg::DATA_RST;
    if (setup)
    begin
      case (paddr)
        mdl_pkg::OFF_CTRL0:
        begin
          next_prdata[mdl_pkg::EN_BIT]    = cfg.en;
          next_prdata[mdl_pkg::OUT_BIT]   = modulated_output_pin;
          next_prdata[mdl_pkg::OUTPUT_INVERT_BIT]  = cfg.output_invert;
          next_prdata[mdl_pkg::SWBIT_BIT] = cfg.swbit;
        end
        mdl_pkg::OFF_CTRL1:
        begin
          next_prdata[mdl_pkg::HIGH_CARRIER_INVERT_BIT]  = cfg.high_carrier_invert;
          next_prdata[mdl_pkg::HIGH_CARRIER_SYNC_ENABLE_BIT] = cfg.high_carrier_sync_enable;
          next_prdata[mdl_pkg::LOW_CARRIER_INVERT_BIT]  = cfg.low_carrier_invert;
          next_prdata[mdl_pkg::LOW_CARRIER_SYNC_ENABLE_BIT] = cfg.low_carrier_sync_enable;
        end
        mdl_pkg::OFF_SRC:
        begin
          next_prdata[mdl_pkg::SEL_W-1:0] = cfg.ms;
        end
        mdl_pkg::OFF_CARRIER_HIGH_SIGNAL:
        begin
          next_prdata[mdl_pkg::SEL_W-1:0] = cfg.ch;
        end
        mdl_pkg::OFF_CARRIER_LOW_SIGNAL:
        begin
          next_prdata[mdl_pkg::SEL_W-1:0] = cfg.cl;
        end
        mdl_pkg::OFF_ROUTE:
        begin
          next_prdata[mdl_pkg::ROUTE_BIT] = cfg.route;
        end
        default:
        begin
          next_pslverr = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      prdata  <= mdl_pkg::DATA_RST;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      prdata  <= next_prdata;
      pready  <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // ****************************************************************
  // source selection
  // ****************************************************************
  mdl_pkg::mdl_sig_t pin_raw;
  mdl_pkg::mdl_sig_t pin_sync;
  logic [4:0]        eff_ms;
  logic [4:0]        eff_ch;
  logic [4:0]        eff_cl;
  logic              mod_lvl;
  logic              carrier_high_signal_raw;
  logic              carrier_low_signal_raw;

  assign pin_raw.modulator_signal  = mod_pin;
  assign pin_raw.carrier_high_signal = carrier_high_signal_pin;
  assign pin_raw.carrier_low_signal = carrier_low_signal_pin;

  mdl_sync2 u_sync
  (
    .core_clk (core_clk),
    .rst      (rst),
    .din      (pin_raw),
    .dout     (pin_sync)
  );

  // stored codes are only masked here, never overwritten, so re-enable restores them
  assign eff_ms = cfg.en ? cfg.ms : mdl_pkg::SRC_SWBIT;
  assign eff_ch = cfg.en ? cfg.ch : mdl_pkg::SRC_VSS;
  assign eff_cl = cfg.en ? cfg.cl : mdl_pkg::SRC_VSS;

  mdl_src_mux u_mod_mux
  (
    .code   (eff_ms),
    .swbit  (cfg.swbit),
    .pin    (pin_sync.modulator_signal),
    .periph (periph_in),
    .sel    (mod_lvl)
  );

  mdl_src_mux u_carrier_high_signal_mux
  (
    .code   (eff_ch),
    .swbit  (cfg.swbit),
    .pin    (pin_sync.carrier_high_signal),
    .periph (periph_in),
    .sel    (carrier_high_signal_raw)
  );

  mdl_src_mux u_carrier_low_signal_mux
  (
    .code   (eff_cl),
    .swbit  (cfg.swbit),
    .pin    (pin_sync.carrier_low_signal),
    .periph (periph_in),
    .sel    (carrier_low_signal_raw)
  );

  // ****************************************************************
  // carrier sync and mixing
  // ****************************************************************
  mdl_pkg::mdl_sel_t use_sel;
  mdl_pkg::mdl_sel_t next_use_sel;
  logic              carrier_high_signal_prev;
  logic              carrier_low_signal_prev;
  logic              next_carrier_high_signal_prev;
  logic              next_carrier_low_signal_prev;
  logic              carrier_high_signal_v;
  logic              carrier_low_signal_v;
  logic              carrier_high_signal_fall;
  logic              carrier_low_signal_fall;
  logic              mixed;
  logic              next_out;
  logic              next_oe;

  always_comb
  begin
    carrier_high_signal_v         = carrier_high_signal_raw ^ cfg.high_carrier_invert;
    carrier_low_signal_v         = carrier_low_signal_raw ^ cfg.low_carrier_invert;
    carrier_high_signal_fall      = carrier_high_signal_prev & ~carrier_high_signal_v;
    carrier_low_signal_fall      = carrier_low_signal_prev & ~carrier_low_signal_v;
    next_carrier_high_signal_prev = carrier_high_signal_v;
    next_carrier_low_signal_prev = carrier_low_signal_v;
    next_use_sel   = use_sel;
    // without sync a switch is immediate, which can clip a carrier pulse
    case (use_sel)
      mdl_pkg::MDL_USE_HIGH:
      begin
        if (!mod_lvl && (!cfg.high_carrier_sync_enable || carrier_high_signal_fall || !cfg.en))
        begin
          next_use_sel = mdl_pkg::MDL_USE_LOW;
        end
      end
      mdl_pkg::MDL_USE_LOW:
      begin
        if (mod_lvl && (!cfg.low_carrier_sync_enable || carrier_low_signal_fall || !cfg.en))
        begin
          next_use_sel = mdl_pkg::MDL_USE_HIGH;
        end
      end
      default:
      begin
        next_use_sel = mdl_pkg::MDL_USE_LOW;
      end
    endcase
    if (next_use_sel == mdl_pkg::MDL_USE_HIGH)
    begin
      mixed = carrier_high_signal_v;
    end
    else
    begin
      mixed = carrier_low_signal_v;
    end
    // disabled: both carriers are ground before the invert, so the pin idles at output_invert
    next_out = (mixed & cfg.en) ^ cfg.output_invert;
    next_oe  = cfg.route;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      use_sel                 <= mdl_pkg::MDL_USE_LOW;
      carrier_high_signal_prev               <= 1'b0;
      carrier_low_signal_prev               <= 1'b0;
      modulated_output_pin    <= 1'b0;
      modulated_output_pin_oe <= 1'b0;
    end
    else
    begin
      use_sel                 <= next_use_sel;
      carrier_high_signal_prev               <= next_carrier_high_signal_prev;
      carrier_low_signal_prev               <= next_carrier_low_signal_prev;
      modulated_output_pin    <= next_out;
      modulated_output_pin_oe <= next_oe;
    end
  end

endmodule // mdl_top

// ===== test/mdl_src_model.sv
// source model: peripheral outputs and input pins that feed the modulator
// assumes: bench sets wanted levels by non-blocking assignment after a rising edge
`timescale 1ns/10ps
module mdl_src_model
(
  input  wire logic        core_clk,
  input  wire logic [10:0] want,
  output      logic        mod_pin,
  output      logic        carrier_high_signal_pin,
  output      logic        carrier_low_signal_pin,
  output      logic [7:0]  periph_in
);
  // ********************
  // drivers
  // ********************
  initial
  begin
    {mod_pin, carrier_high_signal_pin, carrier_low_signal_pin} = 3'h0;
    periph_in = 8'h00;
  end
  // pins move one edge after the bench asks; the design still treats them as asynchronous
  always @(posedge core_clk)
  begin
    {mod_pin, carrier_high_signal_pin, carrier_low_signal_pin} <= want[10:8];
  end
  // unused outputs keep toggling so a stray selection cannot hide
  always @(posedge core_clk)
  begin
    periph_in <= {~periph_in[7:3], want[2:0]};
  end
endmodule // mdl_src_model

// ===== test/mdl_top_chk_sva.sv
// checker: apb handshake, pin enable and status relations at the modulator's ports
// assumes: one core_clk domain, synchronous active-high rst
`timescale 1ns/10ps
module mdl_top_chk
(
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        modulated_output_pin,
  input wire logic        modulated_output_pin_oe
);
  // ********************
  // properties
  // ********************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  logic wr_route;
  assign wr_route = psel && penable && pready && pwrite && (paddr == mdl_pkg::OFF_ROUTE);

  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("no ready one cycle after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_err_zero_data: assert property (pslverr |-> prdata == mdl_pkg::DATA_RST)
    else $error("refused access returned data");
  a_unmapped_err: assert property (psel && !penable && paddr > mdl_pkg::OFF_ROUTE |=> pslverr)
    else $error("unmapped address not refused");
  a_mapped_ok: assert property (psel && !penable && paddr <= mdl_pkg::OFF_ROUTE
    && paddr[1:0] == 2'h0 |=> !pslverr) else $error("mapped address refused");
  // the route bit lands on the commit edge and reaches the pin enable one edge later
  a_route_to_oe: assert property (wr_route |-> ##2
    modulated_output_pin_oe == $past(pwdata[mdl_pkg::ROUTE_BIT], 2))
    else $error("pin enable does not follow route write");
  a_oe_holds: assert property (!$stable(modulated_output_pin_oe) |-> $past(wr_route, 2))
    else $error("pin enable moved without route write");
  a_status_mirror: assert property (psel && pready && !pwrite
    && paddr == mdl_pkg::OFF_CTRL0 && $stable(modulated_output_pin)
    |-> prdata[mdl_pkg::OUT_BIT] == modulated_output_pin) else $error("status bit differs");
  a_reset_quiet: assert property (disable iff (1'b0) rst |=>
    !modulated_output_pin && !modulated_output_pin_oe && !pready)
    else $error("outputs active after reset");

  c_route: cover property (wr_route);
  c_refused: cover property (pslverr);
  c_out_rise: cover property ($rose(modulated_output_pin));
endmodule // mdl_top_chk

bind mdl_top mdl_top_chk u_chk (.core_clk(core_clk), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .modulated_output_pin(modulated_output_pin),
  .modulated_output_pin_oe(modulated_output_pin_oe));

// ===== test/tb.sv
// testbench: apb register tasks and source sequences for the modulator
// assumes: mdl_top and mdl_src_model compiled before, checker bound by its own file
`timescale 1ns/10ps
module tb;
  // ********************
  // signals
  // ********************
  logic        core_clk;
  logic        rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        mod_pin;
  logic        carrier_high_signal_pin;
  logic        carrier_low_signal_pin;
  logic [7:0]  periph_in;
  logic        out_pin;
  logic        out_oe;
  logic [10:0] want;
  logic [31:0] rd;
  logic        err;
  int          n_mismatch;
  int          tests_run;

  mdl_top dut (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mod_pin(mod_pin), .carrier_high_signal_pin(carrier_high_signal_pin), .carrier_low_signal_pin(carrier_low_signal_pin),
    .periph_in(periph_in), .modulated_output_pin(out_pin), .modulated_output_pin_oe(out_oe));
  mdl_src_model u_src (.core_clk(core_clk), .want(want), .mod_pin(mod_pin),
    .carrier_high_signal_pin(carrier_high_signal_pin), .carrier_low_signal_pin(carrier_low_signal_pin), .periph_in(periph_in));

  always #2 core_clk = ~core_clk;

  // ********************
  // tasks
  // ********************
  task automatic tally_and_finish;
    if (n_mismatch == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge core_clk);
      k++;
    end
    while (pready !== 1'b1 && k < 50);
    if (k >= 50)
    begin
      n_mismatch++;
      tally_and_finish();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(nm, e, rd);
    chk("slverr", {31'h0, a > mdl_pkg::OFF_ROUTE}, {31'h0, err});
  endtask

  // pin sources need a model edge, two sync edges and the output edge, plus one spare
  task automatic chk_out(input logic e);
    repeat (5) @(posedge core_clk);
    chk("output", {31'h0, e}, {31'h0, out_pin});
  endtask

  // levels are {carrier_low_signal, carrier_high_signal, mod} on pins and on periph 2..0
  task automatic src(input logic [2:0] p, input logic [2:0] v);
    want <= {p[0], p[1], p[2], 5'h0, v};
  endtask

  // ********************
  // sequence
  // ********************
  initial
  begin
    core_clk = 1'b0;
    rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    want = 11'h0;
    n_mismatch = 0;
    tests_run = 0;
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    for (int i = 0; i < 7; i++) rdchk("reset_reg", 8'(i * 4), 32'h0);
    chk("pins", 32'h0, {30'h0, out_oe, out_pin});
    wr(mdl_pkg::OFF_CTRL1, 32'hFFFF_FFFF);
    rdchk("ctrl1", mdl_pkg::OFF_CTRL1, 32'h0000_0033);
    wr(mdl_pkg::OFF_CTRL1, 32'h0);
    wr(mdl_pkg::OFF_CTRL0, 32'h0000_0011);
    rdchk("ctrl0", mdl_pkg::OFF_CTRL0, 32'h0000_0031);
    for (int i = 0; i < 3; i++) wr(8'(8 + i * 4), 32'(mdl_pkg::SRC_PERIPH + 5'(i)));
    src(3'h0, 3'h7);
    wr(mdl_pkg::OFF_CTRL0, 32'h0000_0001);
    chk_out(1'b0);
    for (int c = 0; c < 32; c++)
    begin
      wr(mdl_pkg::OFF_CTRL1, c[4] ? 32'h22 : 32'h0);
      wr(mdl_pkg::OFF_CTRL0, {24'h0, 1'b1, 2'b0, c[3], 4'h0});
      src(3'h0, c[2:0]);
      chk_out((c[0] ? c[1] : c[2]) ^ c[4] ^ c[3]);
    end
    wr(mdl_pkg::OFF_CTRL1, 32'h0);
    src(3'h0, 3'h3);
    wr(mdl_pkg::OFF_CTRL0, 32'h0);
    chk_out(1'b0);
    rdchk("mod_src", mdl_pkg::OFF_SRC, 32'(mdl_pkg::SRC_PERIPH));
    wr(mdl_pkg::OFF_CTRL0, 32'h80);
    chk_out(1'b1);
    chk("oe", 32'h0, {31'h0, out_oe});
    wr(mdl_pkg::OFF_SRC, 32'(mdl_pkg::SRC_SWBIT));
    src(3'h0, 3'h2);
    wr(mdl_pkg::OFF_CTRL0, 32'h81);
    chk_out(1'b1);
    wr(mdl_pkg::OFF_CTRL0, 32'h80);
    chk_out(1'b0);
    wr(mdl_pkg::OFF_SRC, 32'(mdl_pkg::SRC_PIN));
    wr(mdl_pkg::OFF_CARRIER_HIGH_SIGNAL, 32'(mdl_pkg::SRC_PIN));
    src(3'h3, 3'h0);
    chk_out(1'b1);
    src(3'h1, 3'h0);
    chk_out(1'b0);
    wr(mdl_pkg::OFF_ROUTE, 32'h1);
    rdchk("route", mdl_pkg::OFF_ROUTE, 32'h1);
    chk("oe", 32'h1, {31'h0, out_oe});
    wr(mdl_pkg::OFF_SRC, 32'(mdl_pkg::SRC_PERIPH));
    wr(mdl_pkg::OFF_CARRIER_HIGH_SIGNAL, 32'(mdl_pkg::SRC_PERIPH + 5'h01));
    wr(mdl_pkg::OFF_CTRL1, 32'h10);
    src(3'h0, 3'h3);
    chk_out(1'b1);
    src(3'h0, 3'h2);
    chk_out(1'b1);
    src(3'h0, 3'h0);
    chk_out(1'b0);
    src(3'h0, 3'h2);
    chk_out(1'b0);
    wr(mdl_pkg::OFF_CTRL1, 32'h01);
    src(3'h0, 3'h4);
    chk_out(1'b1);
    src(3'h0, 3'h5);
    chk_out(1'b1);
    src(3'h0, 3'h1);
    chk_out(1'b0);
    src(3'h0, 3'h3);
    chk_out(1'b1);
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    rdchk("ctrl0_rst", mdl_pkg::OFF_CTRL0, 32'h0);
    chk("pins_rst", 32'h0, {30'h0, out_oe, out_pin});
    tally_and_finish();
  end
endmodule // tb
